// file: rtl/umc_mode_regs.vh
// Constants for the UART mode and control block
`ifndef UMC_MODE_REGS_VH
`define UMC_MODE_REGS_VH

// Timing: host reset pulse and clock period, both in ns
`define UMC_CLK_PERIOD_NS 40
`define UMC_RST_MIN_NS 40
// Least time rounds up, never below one cycle
`define UMC_RST_MIN_CYC_RAW ((`UMC_RST_MIN_NS + `UMC_CLK_PERIOD_NS - 1) / `UMC_CLK_PERIOD_NS)
`define UMC_RST_MIN_CYC ((`UMC_RST_MIN_CYC_RAW < 1) ? 1 : `UMC_RST_MIN_CYC_RAW)
`define UMC_RST_CNT_W 4
`define UMC_RST_CNT_ZERO 4'h0
`define UMC_RST_CNT_ONE 4'h1

// Bus style select pin levels
`define UMC_STYLE_STROBE 1'h1
`define UMC_STYLE_RWLINE 1'h0

// Duplex select pin level for half duplex
`define UMC_DUPLEX_HALF 1'h1

// Channel indexes and count
`define UMC_NUM_CHAN 2
`define UMC_CHAN_A 0
`define UMC_CHAN_B 1
`define UMC_CHAN_ADDR_A 1'h0
`define UMC_CHAN_ADDR_B 1'h1

// Serial line idle (mark) level
`define UMC_LINE_IDLE 1'h1

// Widths and bus idle values
`define UMC_ADDR_W 3
`define UMC_DATA_W 8
`define UMC_ADDR_IDLE 3'h0
`define UMC_DATA_IDLE 8'h00
`define UMC_CHAN_IDLE 2'h0
`define UMC_CHAN_MARK 2'h3

// Reset sequencer states, one-hot
`define UMC_ST_RUN 3'h1
`define UMC_ST_HOLD 3'h2
`define UMC_ST_SYNC 3'h4

`endif

// file: rtl/umc_sync.v
// Two-flop level synchroniser
`timescale 1ns/1ps

module umc_sync
(
    input wire mclk,
    input wire resetn,
    input wire d,
    output wire q
);

reg meta_r;
reg sync_r;

always @(posedge mclk)
begin
    if (!resetn)
    begin
        meta_r <= 1'h0;
        sync_r <= 1'h0;
    end
    else
    begin
        meta_r <= d;
        sync_r <= meta_r;
    end
end

assign q = sync_r;

endmodule // umc_sync

// file: rtl/umc_mode_ctrl.v
// Mode, reset, bus isolation and transceiver control of a dual UART
`timescale 1ns/1ps
`include "umc_mode_regs.vh"

module umc_mode_ctrl
(
    input wire mclk,
    input wire resetn,
    // Mode pins
    input wire bus_style_sel,
    input wire host_reset_pin,
    input wire duplex_select_a,
    input wire duplex_select_b,
    input wire bus_isolate_request,
    input wire pump_autosleep,
    input wire osc_input,
    input wire uart_sleep,
    input wire rx_b_single_sel,
    // Host bus pins
    input wire host_cs_a_n,
    input wire second_chip_select,
    input wire host_rd_n,
    input wire host_wr_n,
    input wire [`UMC_ADDR_W-1:0] host_addr,
    input wire [`UMC_DATA_W-1:0] host_wdata,
    // Host bus towards the UART core
    output reg core_cs_a,
    output reg core_cs_b,
    output reg core_rd,
    output reg core_wr,
    output reg [`UMC_ADDR_W-1:0] core_addr,
    output reg [`UMC_DATA_W-1:0] core_wdata,
    // Interrupts from the core and the pins
    input wire core_irq_a,
    input wire core_irq_b,
    input wire core_irq_out_en,
    output reg irq_channel_a_o,
    output reg irq_channel_a_oe,
    output reg irq_channel_b_o,
    output reg irq_channel_b_oe,
    // Serial data between core and line
    input wire [`UMC_NUM_CHAN-1:0] core_tx_data,
    input wire [`UMC_NUM_CHAN-1:0] core_tx_drive,
    input wire [`UMC_NUM_CHAN-1:0] line_rx_data,
    input wire chan_b_serial_in,
    output reg [`UMC_NUM_CHAN-1:0] core_rx_data,
    output reg [`UMC_NUM_CHAN-1:0] line_tx_data,
    output reg [`UMC_NUM_CHAN-1:0] line_drv_en,
    output reg [`UMC_NUM_CHAN-1:0] line_rcv_en,
    output reg [`UMC_NUM_CHAN-1:0] half_duplex,
    output reg chan_b_serial_out,
    // Reset, oscillator and pump
    output reg uart_reset,
    output reg osc_output,
    output reg pump_enable
);

////////////////////////////////////////////////////////////////////////////////
// Reset pin decode and sequencer
wire reset_raw;
wire reset_sync;
reg [2:0] rst_state_r;
reg [2:0] rst_state_nxt;
reg [`UMC_RST_CNT_W-1:0] rst_cnt_r;
reg [`UMC_RST_CNT_W-1:0] rst_cnt_nxt;
wire rst_min_met;
wire uart_reset_nxt;
// Polarity follows the bus style pin
assign reset_raw = (bus_style_sel == `UMC_STYLE_STROBE) ? host_reset_pin : ~host_reset_pin;
umc_sync u_rst_sync
(
    .mclk(mclk),
    .resetn(resetn),
    .d(reset_raw),
    .q(reset_sync)
);
assign rst_min_met = (rst_cnt_r >= `UMC_RST_MIN_CYC);

always @*
begin
    rst_state_nxt = rst_state_r;
    rst_cnt_nxt = rst_cnt_r;
    case (rst_state_r)
        `UMC_ST_RUN:
        begin
            // Entry into hold already counts the edge that saw the pin
            rst_cnt_nxt = `UMC_RST_CNT_ONE;
            if (reset_raw)
                rst_state_nxt = `UMC_ST_HOLD;
        end
        `UMC_ST_HOLD:
        begin
            if (!rst_min_met)
                rst_cnt_nxt = rst_cnt_r + `UMC_RST_CNT_ONE;
            if (!reset_raw && rst_min_met)
                rst_state_nxt = `UMC_ST_SYNC;
        end
        `UMC_ST_SYNC:
        begin
            // Wait until the synchronised copy also shows release
            if (reset_raw)
                rst_state_nxt = `UMC_ST_HOLD;
            else if (!reset_sync)
                rst_state_nxt = `UMC_ST_RUN;
        end
        default:
        begin
            rst_state_nxt = `UMC_ST_HOLD;
            rst_cnt_nxt = `UMC_RST_CNT_ZERO;
        end
    endcase
end

// Raw pin term makes assertion take effect at the very next edge
assign uart_reset_nxt = reset_raw || (rst_state_r != `UMC_ST_RUN);

always @(posedge mclk)
begin
    if (!resetn)
    begin
        rst_state_r <= `UMC_ST_HOLD;
        rst_cnt_r <= `UMC_RST_CNT_ZERO;
        uart_reset <= 1'h1;
    end
    else
    begin
        rst_state_r <= rst_state_nxt;
        rst_cnt_r <= rst_cnt_nxt;
        uart_reset <= uart_reset_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Oscillator and charge pump
wire osc_output_nxt = osc_input & ~uart_sleep;
always @(posedge mclk)
begin
    if (!resetn)
    begin
        osc_output <= 1'h0;
        pump_enable <= 1'h1;
    end
    else
    begin
        osc_output <= osc_output_nxt;
        // Uses the driven oscillator output, so pump stops only once sleep shows on the pin
        pump_enable <= ~(pump_autosleep & ~osc_output);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Host bus decode and isolation
reg cs_a_nxt;
reg cs_b_nxt;
reg rd_nxt;
reg wr_nxt;
wire isolate = bus_isolate_request & uart_sleep;

always @*
begin
    cs_a_nxt = 1'h0;
    cs_b_nxt = 1'h0;
    rd_nxt = 1'h0;
    wr_nxt = 1'h0;
    // No select or strobe reaches the core while isolated or while its reset is pending
    if (!isolate && !uart_reset_nxt)
    begin
        if (bus_style_sel == `UMC_STYLE_STROBE)
        begin
            // Separate chip selects, separate low-active strobes
            cs_a_nxt = ~host_cs_a_n;
            cs_b_nxt = ~second_chip_select;
            rd_nxt = ~host_rd_n;
            wr_nxt = ~host_wr_n;
        end
        else
        begin
            // One chip select; write pin is read-high / write-low
            cs_a_nxt = ~host_cs_a_n & (second_chip_select == `UMC_CHAN_ADDR_A);
            cs_b_nxt = ~host_cs_a_n & (second_chip_select == `UMC_CHAN_ADDR_B);
            rd_nxt = host_wr_n;
            wr_nxt = ~host_wr_n;
        end
    end
end
always @(posedge mclk)
begin
    if (!resetn)
    begin
        core_cs_a <= 1'h0;
        core_cs_b <= 1'h0;
        core_rd <= 1'h0;
        core_wr <= 1'h0;
        core_addr <= `UMC_ADDR_IDLE;
        core_wdata <= `UMC_DATA_IDLE;
    end
    else
    begin
        core_cs_a <= cs_a_nxt;
        core_cs_b <= cs_b_nxt;
        core_rd <= rd_nxt;
        core_wr <= wr_nxt;
        // Address and data frozen while isolated to stop toggling inside
        if (!isolate)
        begin
            core_addr <= host_addr;
            core_wdata <= host_wdata;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt pins
always @(posedge mclk)
begin
    if (!resetn || uart_reset_nxt)
    begin
        irq_channel_a_o <= 1'h0;
        irq_channel_a_oe <= 1'h0;
        irq_channel_b_o <= 1'h0;
        irq_channel_b_oe <= 1'h0;
    end
    else if (bus_style_sel == `UMC_STYLE_STROBE)
    begin
        irq_channel_a_o <= core_irq_a;
        irq_channel_a_oe <= core_irq_out_en;
        irq_channel_b_o <= core_irq_b;
        irq_channel_b_oe <= core_irq_out_en;
    end
    else
    begin
        // Shared open drain: only ever pulls low
        irq_channel_a_o <= 1'h0;
        irq_channel_a_oe <= core_irq_a | core_irq_b;
        irq_channel_b_o <= 1'h0;
        irq_channel_b_oe <= 1'h0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-channel transceiver control
wire [`UMC_NUM_CHAN-1:0] duplex_pin;
wire [`UMC_NUM_CHAN-1:0] rx_source;
assign duplex_pin[`UMC_CHAN_A] = duplex_select_a;
assign duplex_pin[`UMC_CHAN_B] = duplex_select_b;
assign rx_source[`UMC_CHAN_A] = line_rx_data[`UMC_CHAN_A];
assign rx_source[`UMC_CHAN_B] = rx_b_single_sel ? chan_b_serial_in : line_rx_data[`UMC_CHAN_B];
genvar ch;
generate
    for (ch = 0; ch < `UMC_NUM_CHAN; ch = ch + 1)
    begin : g_chan
        wire half = (duplex_pin[ch] == `UMC_DUPLEX_HALF);
        always @(posedge mclk)
        begin
            if (!resetn || uart_reset_nxt)
            begin
                // Line held at mark, received data ignored
                line_tx_data[ch] <= `UMC_LINE_IDLE;
                core_rx_data[ch] <= `UMC_LINE_IDLE;
                line_drv_en[ch] <= 1'h0;
                line_rcv_en[ch] <= 1'h1;
                half_duplex[ch] <= half;
            end
            else
            begin
                line_tx_data[ch] <= core_tx_data[ch];
                half_duplex[ch] <= half;
                // Half duplex shares the pair, so the receiver is off while driving
                line_drv_en[ch] <= half ? core_tx_drive[ch] : 1'h1;
                line_rcv_en[ch] <= half ? ~core_tx_drive[ch] : 1'h1;
                core_rx_data[ch] <= (half && core_tx_drive[ch]) ? `UMC_LINE_IDLE : rx_source[ch];
            end
        end
    end
endgenerate

always @(posedge mclk)
begin
    if (!resetn || uart_reset_nxt)
        chan_b_serial_out <= `UMC_LINE_IDLE;
    else
        chan_b_serial_out <= core_tx_data[`UMC_CHAN_B];
end

endmodule // umc_mode_ctrl

// file: testbench/umc_mode_ctrl_assertions.sv
// Concurrent checks of the UART mode and control block
`timescale 1ns/1ps
module umc_mode_ctrl_checker
(
    input wire mclk,
    input wire resetn,
    input wire bus_style_sel,
    input wire host_reset_pin,
    input wire duplex_select_a,
    input wire duplex_select_b,
    input wire bus_isolate_request,
    input wire pump_autosleep,
    input wire uart_sleep,
    input wire host_cs_a_n,
    input wire second_chip_select,
    input wire host_wr_n,
    input wire core_irq_a,
    input wire core_irq_b,
    input wire [1:0] core_tx_drive,
    input wire core_cs_a,
    input wire core_cs_b,
    input wire core_rd,
    input wire core_wr,
    input wire irq_channel_a_o,
    input wire irq_channel_a_oe,
    input wire irq_channel_b_oe,
    input wire [1:0] core_rx_data,
    input wire [1:0] line_tx_data,
    input wire [1:0] line_drv_en,
    input wire [1:0] line_rcv_en,
    input wire uart_reset,
    input wire osc_output,
    input wire pump_enable
);
    // Outputs follow last inputs only with reset off on both edges
    wire live = resetn && !uart_reset;
    wire iso = bus_isolate_request && uart_sleep;
    wire rst_act = host_reset_pin == bus_style_sel;
    wire rw_read = !bus_style_sel && !host_cs_a_n && host_wr_n;
    wire drv_b = core_tx_drive[1];
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////
    iso_block_a:
        assert property ($past(live) && $past(iso) && live |-> !(core_cs_a || core_cs_b || core_rd || core_wr))
        else $error("bus passed while isolated");
    full_dup_a_a:
        assert property ($past(live) && !$past(duplex_select_a) && live |-> line_drv_en[0] && line_rcv_en[0])
        else $error("channel A not full duplex");
    half_dup_b_a:
        assert property ($past(live) && $past(duplex_select_b) && live |-> line_drv_en[1] == $past(drv_b)
            && line_rcv_en[1] != $past(drv_b)) else $error("channel B not half duplex");
    pump_off_a:
        assert property ($past(resetn) |-> pump_enable == !($past(pump_autosleep) && !$past(osc_output)))
        else $error("pump state wrong");
    rst_pol_a:
        assert property ($past(resetn) && $past(rst_act) |-> uart_reset)
        else $error("reset pin ignored");
    rst_idle_a:
        assert property (uart_reset |-> line_tx_data == 2'h3 && core_rx_data == 2'h3)
        else $error("serial lines active in reset");
    irq_share_a:
        assert property ($past(live) && !$past(bus_style_sel) && live |-> !irq_channel_a_o && !irq_channel_b_oe
            && irq_channel_a_oe == ($past(core_irq_a) || $past(core_irq_b))) else $error("shared interrupt wrong");
    chan_addr_a:
        assert property ($past(live) && !$past(iso) && $past(rw_read) && live
            |-> core_rd && core_cs_b == $past(second_chip_select) && core_cs_a != core_cs_b)
        else $error("channel address decode wrong");
    cover property ($past(live) && $past(iso) && live);
    cover property (live && duplex_select_b && line_drv_en[1]);
    cover property (live && irq_channel_a_oe && !bus_style_sel);
endmodule // umc_mode_ctrl_checker
bind umc_mode_ctrl umc_mode_ctrl_checker i_umc_mode_ctrl_checker (.*);

// file: testbench/umc_line_partner.sv
// Line side model: far transmitter and shared half duplex pair
`timescale 1ns/1ps
module umc_line_partner
(
    input wire duplex_select_a,
    input wire duplex_select_b,
    input wire [1:0] far_bits,
    input wire [1:0] line_tx_data,
    input wire [1:0] line_drv_en,
    output wire [1:0] line_rx_data
);
    // Half duplex is one pair, so the device hears its own driver
    wire [1:0] shared = {duplex_select_b, duplex_select_a} & line_drv_en;
    assign line_rx_data = (shared & line_tx_data) | (~shared & far_bits);
endmodule // umc_line_partner

// file: testbench/umc_mode_ctrl_bench.sv
// Self-checking bench of the UART mode and control block
`timescale 1ns/1ps
module umc_mode_ctrl_bench;
    logic mclk = 0, resetn = 0, bus_style_sel = 1, host_reset_pin = 0, duplex_select_a = 0, duplex_select_b = 0;
    logic bus_isolate_request = 0, pump_autosleep = 0, osc_input = 1, uart_sleep = 0, rx_b_single_sel = 0;
    logic host_cs_a_n = 1, second_chip_select = 1, host_rd_n = 1, host_wr_n = 1, chan_b_serial_in = 1;
    logic core_irq_a = 0, core_irq_b = 0, core_irq_out_en = 0;
    logic [2:0] host_addr = 3'h0;
    logic [7:0] host_wdata = 8'h00;
    logic [1:0] core_tx_data = 2'h3, core_tx_drive = 2'h0, far_bits = 2'h3;
    wire core_cs_a, core_cs_b, core_rd, core_wr, irq_channel_a_o, irq_channel_a_oe, irq_channel_b_o, irq_channel_b_oe;
    wire chan_b_serial_out, uart_reset, osc_output, pump_enable;
    wire [2:0] core_addr;
    wire [7:0] core_wdata;
    wire [1:0] core_rx_data, line_tx_data, line_drv_en, line_rcv_en, half_duplex, line_rx_data;
    int failures = 0, tests_run = 0, cycles = 0, i;
    umc_mode_ctrl i_umc_mode_ctrl (.*);
    umc_line_partner i_umc_line_partner (.*);
    initial forever #20 mclk = ~mclk;
    // About 100 cycles needed; generous margin for slow release
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            failures++;
            tally_and_finish;
        end
    end
    ////////////////////////////////////////////////////////////
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task bus(input logic [3:0] c, input logic [7:0] d);
        @(posedge mclk);
        {host_cs_a_n, second_chip_select, host_rd_n, host_wr_n} <= c;
        host_addr <= d[2:0];
        host_wdata <= d;
        settle(1);
    endtask
    task wait_run;
        for (i = 0; i < 12 && uart_reset !== 1'h0; i++)
            @(posedge mclk);
        settle(1);
        chk(uart_reset, 8'h00);
    endtask
    task pin_reset(input logic act);
        @(posedge mclk);
        host_reset_pin <= act;
        core_tx_data <= 2'h0;
        settle(1);
        chk({uart_reset, line_tx_data, core_rx_data}, 8'h1f);
        @(posedge mclk);
        host_reset_pin <= !act;
        wait_run;
    endtask
    task irq(input logic [2:0] v, input logic [7:0] e);
        @(posedge mclk);
        {core_irq_out_en, core_irq_a, core_irq_b} <= v;
        settle(1);
        chk({irq_channel_a_o, irq_channel_a_oe, irq_channel_b_o, irq_channel_b_oe}, e);
    endtask
    task tally_and_finish;
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        settle(11);
        chk({uart_reset, pump_enable, line_tx_data, core_rx_data, line_drv_en}, 8'hfc);
        @(posedge mclk);
        resetn <= 1'h1;
        wait_run;
        bus(4'h6, 8'ha5);
        chk({core_cs_a, core_cs_b, core_rd, core_wr}, 8'h09);
        chk(core_wdata, 8'ha5);
        chk(core_addr, 8'h05);
        bus(4'h9, 8'h3c);
        chk({core_cs_a, core_cs_b, core_rd, core_wr}, 8'h06);
        pin_reset(1'h1);
        @(posedge mclk);
        bus_style_sel <= 1'h0;
        host_reset_pin <= 1'h1;
        for (i = 0; i < 4; i++)
        begin
            bus({1'h0, i[1], 1'h1, i[0]}, 8'h00);
            chk({core_cs_a, core_cs_b, core_rd, core_wr}, {4'h0, !i[1], i[1], i[0], !i[0]});
        end
        irq(3'h1, 8'h04);
        irq(3'h6, 8'h04);
        irq(3'h0, 8'h00);
        pin_reset(1'h0);
        @(posedge mclk);
        bus_style_sel <= 1'h1;
        host_reset_pin <= 1'h0;
        irq(3'h6, 8'h0d);
        irq(3'h3, 8'h0a);
        @(posedge mclk);
        uart_sleep <= 1'h1;
        bus_isolate_request <= 1'h1;
        bus(4'h6, 8'h5a);
        chk({core_cs_a, core_cs_b, core_rd, core_wr}, 8'h00);
        chk(core_wdata, 8'h00);
        @(posedge mclk);
        bus_isolate_request <= 1'h0;
        settle(1);
        chk({core_cs_a, core_wr, pump_enable}, 8'h07);
        chk(core_wdata, 8'h5a);
        chk(core_addr, 8'h02);
        @(posedge mclk);
        pump_autosleep <= 1'h1;
        settle(1);
        chk({osc_output, pump_enable}, 8'h00);
        @(posedge mclk);
        uart_sleep <= 1'h0;
        settle(2);
        chk({osc_output, pump_enable}, 8'h03);
        for (i = 0; i < 8; i++)
        begin
            @(posedge mclk);
            {duplex_select_a, duplex_select_b} <= {2{i[2]}};
            core_tx_drive <= {2{i[1]}};
            core_tx_data <= {2{i[0]}};
            far_bits <= {2{!i[0]}};
            settle(2);
            chk({half_duplex, line_drv_en, line_rcv_en, line_tx_data}, {{2{i[2]}}, (i[2] ? {2{i[1]}} : 2'h3),
                (i[2] ? {2{!i[1]}} : 2'h3), {2{i[0]}}});
            chk({core_rx_data, chan_b_serial_out}, {((i[2] && i[1]) ? 2'h3 : {2{!i[0]}}), i[0]});
        end
        @(posedge mclk);
        core_tx_drive <= 2'h0;
        far_bits <= 2'h3;
        rx_b_single_sel <= 1'h1;
        chan_b_serial_in <= 1'h0;
        settle(2);
        chk(core_rx_data, 8'h01);
        tally_and_finish;
    end
endmodule // umc_mode_ctrl_bench
